// [exd_decoder.sv]
/*
  extended instruction decoder: holds a pending extension word and decodes
  the following instruction word into one registered decode record.
  assumes instruction words, register nibble and carry come from cpu logic
  on the same clock.
*/
`timescale 1ns/10ps
module exd_decoder (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_nrst,
  // instruction stream
  input  wire logic             i_word_valid,
  input  wire logic [15:0]      i_word,
  input  wire logic [3:0]       i_rpt_reg_nib,
  input  wire logic             i_carry,
  // 20-bit memory pair
  input  wire logic             i_mem_valid,
  input  wire logic [15:0]      i_mem_lo,
  input  wire logic [15:0]      i_mem_hi,
  input  wire logic             i_store_valid,
  input  wire logic [19:0]      i_store_data,
  // decode results
  output logic                  o_dec_valid,
  output exd_pkg::exd_dec_t     o_dec,
  output logic                  o_illegal,
  output logic                  o_ext_pending,
  output logic [3:0]            o_rpt_reg_sel,
  // 20-bit memory results
  output logic                  o_opnd_valid,
  output logic [19:0]           o_opnd20,
  output logic                  o_store_out_valid,
  output logic [15:0]           o_store_lo,
  output logic [15:0]           o_store_hi
);
  import exd_pkg::*;

  logic [15:0] ext_q;
  logic        w_is_ext;
  logic        take;
  logic        is_f1, is_f2, is_addr, is_shift, is_multi, is_call;
  logic        regmode, src_ext, dst_mem, f2_swap_sxt;
  logic [1:0]  sc, dc;
  logic [3:0]  ri;
  exd_dec_t    dec_d;
  logic        ill_d;

  // extension word recognition
  assign w_is_ext = (i_word[15:11] == EXD_EXT_OPC);
  assign take     = i_word_valid && !w_is_ext;

  // instruction class
  assign is_f1    = (i_word[15:12] >= 4'h4);
  assign is_f2    = (i_word[15:10] == 6'b000100) && (i_word[9:8] != 2'b11);
  assign is_call  = (i_word[15:8] == 8'h13) && (i_word[7:4] != 4'h0);
  assign is_shift = (i_word[15:12] == 4'h0) && (i_word[7:5] == 3'b010);
  assign is_addr  = (i_word[15:12] == 4'h0) && !is_shift;
  assign is_multi = (i_word[15:10] == 6'b000101);
  assign f2_swap_sxt = is_f2 && i_word[7];

  // register mode and operand placement of the following word
  assign regmode = is_f1 ? (i_word[5:4] == 2'b00 && !i_word[EXD_AD_BIT])
                         : (i_word[5:4] == 2'b00);
  assign src_ext = (i_word[5:4] == 2'b01) || (i_word[5:4] == 2'b11 && i_word[11:8] == 4'h0);
  assign dst_mem = is_f1 && i_word[EXD_AD_BIT];

  // source and destination classes for cycle lookup
  always_comb begin
    if (i_word[5:4] == 2'b00) sc = 2'd0;
    else if (i_word[5:4] == 2'b01) sc = 2'd3;
    else if (i_word[5:4] == 2'b11 && i_word[11:8] == 4'h0) sc = 2'd2;
    else sc = 2'd1;
    if (dst_mem) dc = 2'd2;
    else if (i_word[3:0] == EXD_REG_PC) dc = 2'd1;
    else dc = 2'd0;
    ri = 4'(sc * 3 + dc);
  end

  // decode of the word following any pending extension
  always_comb begin
    dec_d           = '0;
    ill_d           = 1'b0;
    dec_d.ext       = o_ext_pending;
    dec_d.carry_in  = i_carry;
    dec_d.size      = i_word[EXD_BW_BIT] ? EXD_SZ_B8 : EXD_SZ_W16;
    dec_d.op        = i_word[15:12];
    if (o_ext_pending && (is_f1 || is_f2)) begin
      // size from length bit and byte/word bit
      case ({ext_q[EXD_AL_BIT], i_word[EXD_BW_BIT]})
        2'b01:   dec_d.size = EXD_SZ_A20;
        2'b10:   dec_d.size = EXD_SZ_W16;
        2'b11:   dec_d.size = EXD_SZ_B8;
        default: dec_d.size = f2_swap_sxt ? EXD_SZ_A20 : EXD_SZ_RSVD;
      endcase
      ill_d = (dec_d.size == EXD_SZ_RSVD);
      if (regmode) begin
        dec_d.layout    = EXD_LAY_REG;
        dec_d.rpt_cnt   = ext_q[EXD_RPT_BIT] ? i_rpt_reg_nib : ext_q[3:0];
        dec_d.carry_in  = ext_q[EXD_ZC_BIT] ? 1'b0 : i_carry;
        dec_d.carry_res = ext_q[EXD_ZC_BIT];
      end else if (is_f1) begin
        dec_d.src_hi = ext_q[10:7];
        dec_d.dst_hi = ext_q[3:0];
        if (src_ext && dst_mem) dec_d.layout = EXD_LAY_BOTH;
        else if (src_ext) dec_d.layout = EXD_LAY_SRC;
        else dec_d.layout = EXD_LAY_DST;
      end else begin
        dec_d.layout = (i_word[5:4] == 2'b01) ? EXD_LAY_DST : EXD_LAY_SRC;
        dec_d.dst_hi = (i_word[5:4] == 2'b01) ? ext_q[3:0] : 4'h0;
      end
    end else if (o_ext_pending) begin
      ill_d = 1'b1;  // extension word before a word it cannot modify
    end
    if (is_f1) begin
      dec_d.cls = EXD_CLS_FMT1;
      case (i_word[15:12])
        4'h4, 4'hC, 4'hD: dec_d.flag_upd = EXD_FLG_NONE;
        4'hB, 4'hF: begin
          dec_d.flag_upd = EXD_FLG_NZC;
          dec_d.v_clr    = 1'b1;
        end
        default: dec_d.flag_upd = EXD_FLG_ALL;
      endcase
      dec_d.cycles = (dec_d.size == EXD_SZ_A20) ? EXD_F1_CYC_A[ri] : EXD_F1_CYC_W[ri];
      if (dc == 2'd2 && (i_word[15:12] == 4'h4 || i_word[15:12] == 4'h9
                         || i_word[15:12] == 4'hB))
        dec_d.cycles = dec_d.cycles - ((dec_d.size == EXD_SZ_A20) ? EXD_CYC_TWO : EXD_CYC_ONE);
      if (regmode && dc == 2'd0)
        dec_d.cycles = 6'(dec_d.rpt_cnt) + EXD_CYC_TWO;
    end else if (is_f2) begin
      dec_d.cls = EXD_CLS_FMT2;
      dec_d.op  = {1'b0, i_word[9:7]};
      if (i_word[9:7] == 3'b001 || i_word[9]) begin
        dec_d.flag_upd = EXD_FLG_NONE;
      end else begin
        dec_d.flag_upd = EXD_FLG_NZC;
        dec_d.v_clr    = 1'b1;
      end
      if (regmode) dec_d.cycles = 6'(dec_d.rpt_cnt) + EXD_CYC_TWO;
      else if (i_word[5:4] == 2'b01)
        dec_d.cycles = (dec_d.size == EXD_SZ_A20) ? 6'h07 : 6'h05;
      else dec_d.cycles = (dec_d.size == EXD_SZ_A20) ? 6'h06 : EXD_CYC_IDX;
    end else if (is_shift) begin
      dec_d.cls       = EXD_CLS_SHIFT;
      dec_d.op        = {2'b00, i_word[9:8]};
      dec_d.size      = i_word[4] ? EXD_SZ_W16 : EXD_SZ_A20;
      dec_d.shift_cnt = {1'b0, i_word[11:10]} + 3'd1;
      dec_d.flag_upd  = (i_word[9:8] == 2'b10) ? EXD_FLG_ALL : EXD_FLG_NZC;
      dec_d.v_clr     = (i_word[9:8] != 2'b10);
      dec_d.cycles    = 6'(dec_d.shift_cnt);
    end else if (is_multi) begin
      dec_d.cls      = EXD_CLS_MULTI;
      dec_d.op       = {2'b00, i_word[9:8]};
      dec_d.size     = i_word[8] ? EXD_SZ_W16 : EXD_SZ_A20;
      dec_d.reg_cnt  = {1'b0, i_word[7:4]} + 5'd1;
      dec_d.flag_upd = EXD_FLG_NONE;
      dec_d.cycles   = EXD_CYC_TWO + (i_word[8] ? 6'(dec_d.reg_cnt) : 6'(dec_d.reg_cnt) * 6'd2);
    end else if (is_addr) begin
      dec_d.cls    = EXD_CLS_ADDR;
      dec_d.op     = i_word[7:4];
      dec_d.size   = EXD_SZ_A20;
      dec_d.src_hi = i_word[11:8];
      if (i_word[7] && (i_word[5:4] != 2'b00)) dec_d.flag_upd = EXD_FLG_ALL;
      else dec_d.flag_upd = EXD_FLG_NONE;
      dec_d.is_return = (i_word[7:4] == 4'h1) && (i_word[11:8] == EXD_REG_SP)
                        && (i_word[3:0] == EXD_REG_PC);
      if (i_word[7:6] == 2'b11)
        dec_d.cycles = (i_word[3:0] == EXD_REG_PC) ? EXD_CYC_IND : EXD_CYC_ONE;
      else if (i_word[7:6] == 2'b10)
        dec_d.cycles = (i_word[5:4] == 2'b00 && i_word[3:0] != EXD_REG_PC) ? EXD_CYC_TWO
                                                                          : EXD_CYC_IND;
      else if (i_word[7:5] == 3'b000)
        dec_d.cycles = EXD_CYC_IND + ((i_word[3:0] == EXD_REG_PC) ? EXD_CYC_TWO : 6'h00);
      else
        dec_d.cycles = EXD_CYC_IDX + ((i_word[3:0] == EXD_REG_PC) ? EXD_CYC_TWO : 6'h00);
    end else if (is_call) begin
      dec_d.cls    = EXD_CLS_CALL;
      dec_d.size   = EXD_SZ_A20;
      dec_d.cycles = EXD_CYC_CALL;
    end else begin
      dec_d.cls = EXD_CLS_BASE;
    end
  end

  // pending extension word
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_q         <= 16'h0000;
      o_ext_pending <= 1'b0;
      o_rpt_reg_sel <= 4'h0;
    end else if (i_word_valid) begin
      o_ext_pending <= w_is_ext;
      if (w_is_ext) begin
        ext_q         <= i_word;
        o_rpt_reg_sel <= i_word[3:0];
      end
    end
  end

  // decode record
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dec_valid <= 1'b0;
      o_dec       <= '0;
      o_illegal   <= 1'b0;
    end else begin
      o_dec_valid <= take;
      o_illegal   <= take && ill_d;
      if (take) o_dec <= dec_d;
    end
  end

  // 20-bit memory values split over two words
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_opnd_valid      <= 1'b0;
      o_opnd20          <= 20'h00000;
      o_store_out_valid <= 1'b0;
      o_store_lo        <= 16'h0000;
      o_store_hi        <= 16'h0000;
    end else begin
      o_opnd_valid      <= i_mem_valid;
      o_store_out_valid <= i_store_valid;
      if (i_mem_valid) o_opnd20 <= {i_mem_hi[3:0], i_mem_lo};
      if (i_store_valid) begin
        o_store_lo <= i_store_data[15:0];
        o_store_hi <= {12'h000, i_store_data[19:16]};
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence s_ext_taken;
    i_word_valid && w_is_ext ##1 o_ext_pending && !o_dec_valid;
  endsequence

  a_ext_word_held: assert property (i_word_valid && w_is_ext |-> s_ext_taken)
    else $error("extension word not held as pending");
  a_rpt_from_word: assert property (take && o_ext_pending && regmode && (is_f1 || is_f2)
      && !ext_q[EXD_RPT_BIT] |=> o_dec.rpt_cnt == $past(ext_q[3:0]))
    else $error("repeat count not taken from extension word");
  a_rpt_from_reg: assert property (take && o_ext_pending && regmode && (is_f1 || is_f2)
      && ext_q[EXD_RPT_BIT] |=> o_dec.rpt_cnt == $past(i_rpt_reg_nib))
    else $error("repeat count not taken from register");
  a_src_upper: assert property (s_ext_taken ##0 take && is_f1 && !regmode
      |=> o_dec.src_hi == $past(ext_q[10:7]) && o_dec.dst_hi == $past(ext_q[3:0]))
    else $error("upper address bits wrong");
  a_size_sel: assert property (take && o_ext_pending && is_f1
      && {ext_q[EXD_AL_BIT], i_word[EXD_BW_BIT]} == 2'b01 |=> o_dec.size == EXD_SZ_A20)
    else $error("20-bit size not selected");
  a_rsvd_size: assert property (take && o_ext_pending && is_f1
      && {ext_q[EXD_AL_BIT], i_word[EXD_BW_BIT]} == 2'b00 |=> o_illegal && o_dec_valid)
    else $error("reserved size not flagged");
  a_zc_carry: assert property (take && o_ext_pending && regmode && is_f1 && ext_q[EXD_ZC_BIT]
      |=> !o_dec.carry_in && o_dec.carry_res)
    else $error("carry zero select ignored");
  a_multi_count: assert property (take && is_multi |=> o_dec.flag_upd == EXD_FLG_NONE
      && o_dec.reg_cnt == 5'($past(i_word[7:4])) + 5'd1)
    else $error("multi push pop decode wrong");
  a_shift_flags: assert property (take && is_shift |=> o_dec.shift_cnt >= 3'd1
      && o_dec.shift_cnt <= 3'd4 && (o_dec.v_clr == (o_dec.op[1:0] != 2'b10)))
    else $error("multi shift decode wrong");
  a_swap_flags: assert property (take && is_f2 && i_word[9:7] == 3'b001
      |=> o_dec.flag_upd == EXD_FLG_NONE && !o_dec.v_clr)
    else $error("byte swap touches flags");
  a_addr_flags: assert property (take && is_addr && i_word[7:4] == 4'hC
      |=> o_dec.flag_upd == EXD_FLG_NONE && o_dec.size == EXD_SZ_A20)
    else $error("address move touches flags");
  a_wide_pair: assert property (i_mem_valid |=> o_opnd_valid
      && o_opnd20 == {$past(i_mem_hi[3:0]), $past(i_mem_lo)})
    else $error("20-bit operand assembled wrong");

endmodule : exd_decoder

// [exd_pkg.sv]
/*
  constants, types and decoded-instruction carrier for the extended decoder.
  assumes one system clock; instruction words arrive one per cycle.
*/
// Functional notes
// - repeat bit clear: low nibble of the extension word is count minus one
// - repeat bit set: low nibble picks a register whose bits 3:0 give count minus one
// - words 1800h..1FFFh are extension words modifying the next instruction
// - non-register extension bits 10:7 are source bits 19:16
// - non-register extension bits 3:0 are destination bits 19:16
// - length bit with byte/word bit: 01 20-bit, 10 16-bit, 11 8-bit, 00 reserved
// - carry-zero select clear uses carry; set forces carry zero, result sets carry
// - all twelve two-operand operations run extended at byte, word and 20-bit sizes
// - four two-operand layouts: register, source, destination, both extended
// - 20-bit memory value: low word at base, bits 19:16 in low nibble at base+2
// - multi push/pop moves 1 to 16 registers and keeps all flags
// - multi shifts take 1 to 4; right shifts clear V, left updates V; NZC updated
// - extended byte swap exchanges bytes and keeps all flags
// - single-operand layouts: register, indirect with zero upper bits, indexed/absolute
// - emulated forms run as core equivalents, e.g. return is 20-bit pop into PC
// - address instructions run 20-bit without extension word
// - address add, compare, subtract update all flags; address move keeps them
// - cycle count follows format and addressing modes, counted in system clocks
package exd_pkg;

  localparam logic [4:0] EXD_EXT_OPC  = 5'h03;  // word[15:11] of an extension word
  localparam int         EXD_ZC_BIT   = 8;
  localparam int         EXD_RPT_BIT  = 7;
  localparam int         EXD_AL_BIT   = 6;
  localparam int         EXD_BW_BIT   = 6;
  localparam int         EXD_AD_BIT   = 7;
  localparam logic [3:0] EXD_FLG_NONE = 4'h0;   // flag masks ordered V,N,Z,C
  localparam logic [3:0] EXD_FLG_ALL  = 4'hF;
  localparam logic [3:0] EXD_FLG_NZC  = 4'h7;
  localparam logic [3:0] EXD_REG_SP   = 4'h1;
  localparam logic [3:0] EXD_REG_PC   = 4'h0;

  // format I extended cycles, index source class * 3 + destination class
  localparam logic [5:0] EXD_F1_CYC_W [0:11] = '{6'h02, 6'h04, 6'h05, 6'h03, 6'h05, 6'h06,
                                                 6'h03, 6'h04, 6'h06, 6'h04, 6'h06, 6'h07};
  localparam logic [5:0] EXD_F1_CYC_A [0:11] = '{6'h02, 6'h04, 6'h07, 6'h04, 6'h06, 6'h09,
                                                 6'h03, 6'h04, 6'h08, 6'h05, 6'h07, 6'h0A};
  localparam logic [5:0] EXD_CYC_CALL = 6'h05;
  localparam logic [5:0] EXD_CYC_ONE  = 6'h01;
  localparam logic [5:0] EXD_CYC_TWO  = 6'h02;
  localparam logic [5:0] EXD_CYC_IND  = 6'h03;
  localparam logic [5:0] EXD_CYC_IDX  = 6'h04;

  typedef enum logic [2:0] {
    EXD_CLS_BASE, EXD_CLS_FMT1, EXD_CLS_FMT2, EXD_CLS_ADDR,
    EXD_CLS_SHIFT, EXD_CLS_MULTI, EXD_CLS_CALL
  } exd_cls_t;

  typedef enum logic [1:0] {EXD_SZ_A20, EXD_SZ_W16, EXD_SZ_B8, EXD_SZ_RSVD} exd_size_t;

  typedef enum logic [1:0] {EXD_LAY_REG, EXD_LAY_SRC, EXD_LAY_DST, EXD_LAY_BOTH} exd_lay_t;

  typedef struct packed {
    exd_cls_t   cls;
    logic [3:0] op;         // operation field of the class
    logic       ext;        // preceded by an extension word
    exd_size_t  size;
    exd_lay_t   layout;
    logic [3:0] src_hi;
    logic [3:0] dst_hi;
    logic [3:0] rpt_cnt;    // repetitions minus one
    logic       carry_in;
    logic       carry_res;  // carry comes from final result
    logic [3:0] flag_upd;
    logic       v_clr;
    logic [2:0] shift_cnt;
    logic [4:0] reg_cnt;
    logic       is_return;
    logic [5:0] cycles;
  } exd_dec_t;

endpackage : exd_pkg

// [exd_pmem.sv]
/*
  program memory model: sixteen words, one word a cycle on fetch, a base and upper word pair in one cycle on pair request.
  assumes requests change at the falling edge of the system clock.
*/
`timescale 1ns/10ps
module exd_pmem (
  // clock
  input  wire logic        i_clk_sys,
  // requests
  input  wire logic        i_fetch,
  input  wire logic        i_pair,
  input  wire logic [3:0]  i_addr,
  // answers
  output logic             o_word_valid,
  output logic [15:0]      o_word,
  output logic             o_mem_valid,
  output logic [15:0]      o_mem_hi
);
  logic [15:0] mem [0:15];
  logic [15:0] last_q = 16'h5A5A;
  // a released bus shows the inverse of the last word, never a stale copy
  always_comb begin
    o_word_valid = i_fetch;
    o_mem_valid  = i_pair;
    o_word       = (i_fetch | i_pair) ? mem[i_addr] : ~last_q;
    o_mem_hi     = i_pair ? mem[4'(i_addr + 4'h1)] : ~last_q;  // upper word at base+1
  end
  // remember the last word driven
  always_ff @(posedge i_clk_sys) begin
    if (i_fetch | i_pair) last_q <= o_word;
  end
endmodule : exd_pmem

// [tb.sv]
/*
  self-checking bench for the extended decoder, fed by the memory model.
  assumes one 100 MHz clock; inputs change at its falling edge.
*/
`timescale 1ns/10ps
module tb;
  import exd_pkg::*;
  // stimulus
  logic        clk = 1'h0;
  logic        nrst = 1'h0;
  logic        fetch = 1'h0;
  logic        pair = 1'h0;
  logic [3:0]  addr = 4'h0;
  logic [3:0]  nib = 4'h0;
  logic        carry = 1'h1;
  logic        st_v = 1'h0;
  logic [19:0] st_d = 20'h0;
  // results
  logic        wv, mv, dv, ill, pend, ov, sov;
  logic [15:0] w, hi, slo, shi;
  logic [3:0]  sel;
  logic [19:0] o20;
  exd_dec_t    dec;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  exd_size_t   szx [4] = '{EXD_SZ_RSVD, EXD_SZ_A20, EXD_SZ_W16, EXD_SZ_B8};
  logic [15:0] exw [4] = '{16'h1800, 16'h1FFF, 16'h17FF, 16'h2000};
  logic [15:0] adw [9] = '{16'h03A5, 16'h0395, 16'h03B5, 16'h03D5, 16'h03E5,
                           16'h03F5, 16'h03C5, 16'h0035, 16'h0015};
  always #5 clk = ~clk;
  exd_pmem pm (.i_clk_sys(clk), .i_fetch(fetch), .i_pair(pair), .i_addr(addr),
    .o_word_valid(wv), .o_word(w), .o_mem_valid(mv), .o_mem_hi(hi));
  exd_decoder uut (.i_clk_sys(clk), .i_nrst(nrst), .i_word_valid(wv), .i_word(w),
    .i_rpt_reg_nib(nib), .i_carry(carry), .i_mem_valid(mv), .i_mem_lo(w), .i_mem_hi(hi),
    .i_store_valid(st_v), .i_store_data(st_d), .o_dec_valid(dv), .o_dec(dec),
    .o_illegal(ill), .o_ext_pending(pend), .o_rpt_reg_sel(sel), .o_opnd_valid(ov),
    .o_opnd20(o20), .o_store_out_valid(sov), .o_store_lo(slo), .o_store_hi(shi));
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // offer words mem[0..n-1] on back-to-back cycles
  task automatic feed(input int n);
    @(negedge clk);
    for (int i = 0; i < n; i++) begin
      fetch = 1'h1;
      addr = 4'(i);
      @(negedge clk);
    end
    fetch = 1'h0;
  endtask : feed
  // optional extension word, then one instruction; record is checked afterwards
  task automatic dec2(input logic [15:0] e, input logic [15:0] iw);
    pm.mem[0] = (e === 16'h0) ? iw : e;
    pm.mem[1] = iw;
    feed((e === 16'h0) ? 1 : 2);
    chk("dec_valid", 32'h1, 32'(dv));
  endtask : dec2
  task automatic lay(input logic [15:0] e, input logic [15:0] iw, input exd_lay_t l,
                     input logic [3:0] s, input logic [3:0] d);
    dec2(e, iw);
    chk("layout", 32'(l), 32'(dec.layout));
    chk("src_hi", 32'(s), 32'(dec.src_hi));
    chk("dst_hi", 32'(d), 32'(dec.dst_hi));
  endtask : lay
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (12) @(negedge clk);
    chk("rst_valid", 32'h0, 32'(dv));
    chk("rst_pend", 32'h0, 32'(pend));
    nrst = 1'h1;
    // extension range edges: pending without decode inside, decode outside
    for (int i = 0; i < 4; i++) begin
      pm.mem[0] = exw[i];
      feed(1);
      chk("ext_pend", 32'(i < 2), 32'(pend));
      chk("ext_nodec", 32'(i > 1), 32'(dv));
      dec2(16'h0, 16'h4405);
    end
    // register mode: repeat source and carry-zero select
    for (int k = 0; k < 4; k++) begin
      nib = 4'(9 + k);
      dec2({5'h03, 2'h0, k[0], k[1], 1'h1, 2'h0, 4'h5}, 16'hE908);
      chk("rpt_cnt", k[1] ? 32'(nib) : 32'h5, 32'(dec.rpt_cnt));
      chk("carry_in", 32'(!k[0]), 32'(dec.carry_in));
      chk("carry_res", 32'(k[0]), 32'(dec.carry_res));
      chk("size16", 32'(EXD_SZ_W16), 32'(dec.size));
      chk("lay_reg", 32'(EXD_LAY_REG), 32'(dec.layout));
      chk("f1_cyc", (k[1] ? 32'(nib) : 32'h5) + 32'h2, 32'(dec.cycles));
      chk("rpt_sel", 32'h5, 32'(sel));
    end
    // all four length combinations
    for (int j = 0; j < 4; j++) begin
      dec2({5'h03, 4'h0, j[1], 2'h0, 4'h0}, 16'hE908 | (16'(j[0]) << 6));
      chk("illegal", 32'(j == 0), 32'(ill));
      if (j != 0) chk("size", 32'(szx[j]), 32'(dec.size));
    end
    // twelve double-operand operations at byte size
    for (int op = 4; op < 16; op++) begin
      dec2(16'h1840, (16'(op) << 12) | 16'h0948);
      chk("f1_cls", 32'(EXD_CLS_FMT1), 32'(dec.cls));
      chk("f1_byte", 32'(EXD_SZ_B8), 32'(dec.size));
      if (op < 11 || op == 12 || op == 13)
        chk("f1_flags", (op == 4 || op > 11) ? 32'h0 : 32'hF, 32'(dec.flag_upd));
    end
    lay(16'h1D40, 16'h4035, EXD_LAY_SRC, 4'hA, 4'h0);
    lay(16'h1843, 16'hE988, EXD_LAY_DST, 4'h0, 4'h3);
    lay(16'h1B4C, 16'hE998, EXD_LAY_BOTH, 4'h6, 4'hC);
    // single-operand: register repeat, indirect, indexed
    dec2(16'h1843, 16'h1005);
    chk("f2_rpt", 32'h3, 32'(dec.rpt_cnt));
    dec2(16'h1D4A, 16'h1025);
    chk("f2_ind_hi", 32'h0, 32'(dec.dst_hi));
    dec2(16'h184A, 16'h1015);
    chk("f2_idx_hi", 32'hA, 32'(dec.dst_hi));
    // byte swap with length 00 is the 20-bit exception and keeps flags
    dec2(16'h1800, 16'h1085);
    chk("swp_ill", 32'h0, 32'(ill));
    chk("swp_size", 32'(EXD_SZ_A20), 32'(dec.size));
    chk("swp_flags", 32'h0, 32'(dec.flag_upd));
    // second extension word replaces the first
    pm.mem[0] = 16'h1841;
    pm.mem[1] = 16'h1847;
    pm.mem[2] = 16'hE908;
    feed(3);
    chk("ext2_rpt", 32'h7, 32'(dec.rpt_cnt));
    chk("ext2_ill", 32'h0, 32'(ill));
    // multi push and pop at both count limits
    for (int m = 0; m < 8; m++) begin
      dec2(16'h0, 16'h1400 | (16'(m / 2) << 8) | (m[0] ? 16'h00FF : 16'h000F));
      chk("m_cnt", m[0] ? 32'h10 : 32'h1, 32'(dec.reg_cnt));
      chk("m_flags", 32'h0, 32'(dec.flag_upd));
      chk("m_cyc", 32'h2 + (m[0] ? 32'h10 : 32'h1) * (m[1] ? 32'h1 : 32'h2),
          32'(dec.cycles));
    end
    // multi-bit shifts, counts 1 and 4
    for (int s = 0; s < 8; s++) begin
      dec2(16'h0, {4'h0, s[0] ? 2'h3 : 2'h0, 2'(s / 2), 4'h5, 4'h5});
      chk("sh_cnt", s[0] ? 32'h4 : 32'h1, 32'(dec.shift_cnt));
      chk("sh_vclr", 32'(s / 2 != 2), 32'(dec.v_clr));
      chk("sh_nzc", 32'h7, 32'(dec.flag_upd[2:0]));
      chk("sh_cyc", s[0] ? 32'h4 : 32'h1, 32'(dec.cycles));
    end
    // address instructions: arithmetic updates flags, moves keep them
    for (int a = 0; a < 9; a++) begin
      dec2(16'h0, adw[a]);
      chk("a_cls", 32'(EXD_CLS_ADDR), 32'(dec.cls));
      chk("a_flags", (a < 6) ? 32'hF : 32'h0, 32'(dec.flag_upd));
    end
    dec2(16'h0, 16'h0110);
    chk("ret", 32'h1, 32'(dec.is_return));
    dec2(16'h0, 16'h1345);
    chk("call_cyc", 32'(EXD_CYC_CALL), 32'(dec.cycles));
    dec2(16'h1840, 16'h03A5);
    chk("a_ext_ill", 32'h1, 32'(ill));
    // 20-bit value read from and split for memory, same cycle
    pm.mem[4] = 16'h1234;
    pm.mem[5] = 16'hFFF5;
    @(negedge clk);
    pair = 1'h1;
    addr = 4'h4;
    st_v = 1'h1;
    st_d = 20'hABCDE;
    @(negedge clk);
    pair = 1'h0;
    st_v = 1'h0;
    chk("opnd20", 32'h51234, 32'(o20));
    chk("opnd_v", 32'h1, 32'(ov));
    chk("st_v", 32'h1, 32'(sov));
    chk("st_lo", 32'hBCDE, 32'(slo));
    chk("st_hi", 32'h000A, 32'(shi));
    test_done();
  end
endmodule : tb
